// ### design/hre_pkg.sv
// Package for the HART response error report block
package hre_pkg;
  // Group error byte field positions
  localparam int unsigned GRP_MORE_BIT = 0;
  localparam int unsigned GRP_COMM_BIT = 1;
  localparam int unsigned GRP_PARM_BIT = 2;
  localparam int unsigned GRP_RSVD_BIT = 3;
  localparam int unsigned GRP_CODE_LSB = 4;
  // Bit of the second status byte that says more status is available
  localparam int unsigned ST2_MORE_BIT = 4;
  localparam int unsigned MAP_FLAG_BIT = 7;

  // Protocol error codes
  localparam logic [3:0] PE_UNSPEC   = 4'h0;
  localparam logic [3:0] PE_MODEM    = 4'h1;
  localparam logic [3:0] PE_CHANNEL  = 4'h2;
  localparam logic [3:0] PE_COMMAND  = 4'h3;
  localparam logic [3:0] PE_QUERY    = 4'h4;
  localparam logic [3:0] PE_REPLY    = 4'h5;
  localparam logic [3:0] PE_REJ      = 4'h6;
  localparam logic [3:0] PE_REJ_PROF = 4'h7;
  localparam logic [3:0] PE_REJ_VEND = 4'h8;
  localparam logic [3:0] PE_LAST     = 4'h8;

  localparam logic [7:0] QUERY_MAP_MASK = 8'h7a;
  localparam logic [7:0] REPLY_MAP_MASK = 8'h7f;
  localparam logic [7:0] CMD_VAL_MASK   = 8'h7f;
  localparam logic [7:0] REJ_MAX        = 8'h04;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] MAP_FLAG       = 8'h80;

  // Receive fault bits as a bit map
  typedef struct packed {
    logic parity;
    logic overrun;
    logic framing;
    logic checksum;
    logic timeout;
    logic rx_overflow;
    logic gap_timeout;
  } hre_rxerr_t;

  // One relayed reply as seen by the block
  typedef struct packed {
    logic [7:0] cmd_num;
    logic [7:0] status1;
    logic [7:0] status2;
    logic       comm_fault;
    logic       field_modem_check;
    logic       proto_err;
    logic [3:0] proto_code;
    logic [7:0] proto_val;
    hre_rxerr_t rxerr;
  } hre_event_t;

  // Response record header produced
  typedef struct packed {
    logic [7:0] last_cmd;
    logic [7:0] group;
    logic [7:0] detail;
  } hre_resp_t;

  typedef enum logic [1:0] {
    HRE_IDLE  = 2'b01,
    HRE_VALID = 2'b10
  } hre_state_t;
endpackage

// ### design/hre_report.sv
// Builds group error byte, detail byte and command echo of a response record
// Notes on behaviour
// - Event flags are one when present, else zero
// - Bit 0 mirrors status byte two bit 4
// - Bit 1 comm fault; status byte one passed when comm fault is set and there is no protocol error
// - Bit 2 set when field modem needs check
// - Bits 4 to 7 hold protocol error code
// - Codes 0 to 8 defined; 9-15 unused
// - Byte 2 carries detail per error code
// - Query fault: bit map, bit 7 set
// - Reply fault: bit map, bit 7 set
// - Rejected query: reason value 0 to 4
// - Profile or vendor rejection: byte 2 zero
// - Echo last command number in reply
`timescale 1ns/1ps
`default_nettype none
module hre_report
  import hre_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       evt_valid,
  input  wire hre_event_t evt,
  output logic            resp_valid,
  output hre_resp_t       resp
);

  // Shared by both bit maps; the mask keeps reserved positions clear
  function automatic logic [7:0] rx_map(input hre_rxerr_t e, input logic [7:0] mask);
    rx_map = (MAP_FLAG | {1'b0, e}) & (mask | MAP_FLAG);
  endfunction

  // State only tells whether a record has been captured since reset
  hre_state_t state_q;
  hre_state_t state_d;
  hre_resp_t  resp_q;
  hre_resp_t  resp_d;
  logic       resp_valid_q;
  logic       resp_valid_d;

  // Unused codes fall back to unspecified so the nibble never shows 9-15
  // unused codes fold
  wire logic [3:0] code_w = (evt.proto_code > PE_LAST) ? PE_UNSPEC : evt.proto_code;
  wire logic [3:0] code_eff = evt.proto_err ? code_w : PE_UNSPEC;
  // Out-of-range reasons are reported as unspecified
  wire logic [7:0] rej_w = (evt.proto_val > REJ_MAX) ? BYTE_ZERO : evt.proto_val;

  logic [7:0] detail_w;
  always_comb begin
    detail_w = BYTE_ZERO;
    if (evt.proto_err) begin
      unique case (code_w)
        PE_COMMAND:  detail_w = evt.proto_val & CMD_VAL_MASK;
        PE_QUERY:    detail_w = rx_map(evt.rxerr, QUERY_MAP_MASK);
        PE_REPLY:    detail_w = rx_map(evt.rxerr, REPLY_MAP_MASK);
        PE_REJ:      detail_w = rej_w;
        PE_REJ_PROF: detail_w = BYTE_ZERO;
        PE_REJ_VEND: detail_w = BYTE_ZERO;
        default:     detail_w = evt.proto_val;
      endcase
    end else if (evt.comm_fault) begin
      detail_w = evt.status1;
    end
  end

  logic [7:0] group_w;
  always_comb begin
    group_w = BYTE_ZERO;
    group_w[GRP_MORE_BIT] = evt.status2[ST2_MORE_BIT];
    group_w[GRP_COMM_BIT] = evt.comm_fault;
    group_w[GRP_PARM_BIT] = evt.field_modem_check;
    group_w[GRP_RSVD_BIT] = 1'b0;
    group_w[GRP_CODE_LSB +: 4] = code_eff;
  end

  always_comb begin
    resp_d = resp_q;
    state_d = state_q;
    resp_valid_d = resp_valid_q;
    if (evt_valid) begin
      resp_d = '{last_cmd: evt.cmd_num, group: group_w, detail: detail_w};
      state_d = HRE_VALID;
      resp_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q      <= HRE_IDLE;
      resp_q       <= '0;
      resp_valid_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      resp_q       <= resp_d;
      resp_valid_q <= resp_valid_d;
    end
  end

  // Valid stays up once set until reset: a record is replaced by the next one, only reset withdraws it
  assign resp_valid = resp_valid_q;
  assign resp = resp_q;

  // Assertions on evt_valid look at the record one edge after the event that built it
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  rsvd_zero_a: assert property (resp_q.group[GRP_RSVD_BIT] == 1'b0)
    else $error("reserved bit set");

  more_mirror_a: assert property (evt_valid |=>
      resp_q.group[GRP_MORE_BIT] == $past(evt.status2[ST2_MORE_BIT]))
    else $error("more status not mirrored");

  comm_flag_a: assert property (evt_valid |=>
      resp_q.group[GRP_COMM_BIT] == $past(evt.comm_fault))
    else $error("comm flag wrong");

  parm_flag_a: assert property (evt_valid |=>
      resp_q.group[GRP_PARM_BIT] == $past(evt.field_modem_check))
    else $error("parameter check wrong");

  code_range_a: assert property (resp_q.group[7:4] <= PE_LAST)
    else $error("unused code reported");

  code_pass_a: assert property (
      evt_valid && evt.proto_err && evt.proto_code <= PE_LAST |=>
      resp_q.group[7:4] == $past(evt.proto_code))
    else $error("code not reported");

  cmd_val_a: assert property (
      resp_q.group[7:4] == PE_COMMAND && resp_valid |-> !resp_q.detail[MAP_FLAG_BIT])
    else $error("command detail bit 7 set");

  query_map_a: assert property (resp_q.group[7:4] == PE_QUERY && resp_valid |->
      resp_q.detail[MAP_FLAG_BIT] && resp_q.detail[0] == 1'b0 && resp_q.detail[2] == 1'b0)
    else $error("query map wrong");

  reply_map_a: assert property (
      evt_valid && evt.proto_err && evt.proto_code == PE_REPLY |=>
      resp_q.detail == {1'b1, $past(evt.rxerr)})
    else $error("reply map wrong");

  rej_val_a: assert property (resp_q.group[7:4] == PE_REJ && resp_valid |->
      resp_q.detail <= REJ_MAX)
    else $error("reject reason out of range");

  rej_zero_a: assert property ((resp_q.group[7:4] == PE_REJ_PROF ||
      resp_q.group[7:4] == PE_REJ_VEND) && resp_valid |-> resp_q.detail == BYTE_ZERO)
    else $error("profile reject detail nonzero");

  cmd_echo_a: assert property (evt_valid |=> resp_q.last_cmd == $past(evt.cmd_num))
    else $error("command not echoed");

  detail_hold_a: assert property (!evt_valid |=> $stable(resp_q))
    else $error("record changed without event");

  valid_match_a: assert property (resp_valid_q == (state_q == HRE_VALID))
    else $error("valid flag disagrees with state");

  valid_set_a: assert property (evt_valid |=> resp_valid_q)
    else $error("record not flagged valid");

  valid_hold_a: assert property (resp_valid_q |=> resp_valid_q)
    else $error("valid flag dropped");

  comm_detail_a: assert property (
      evt_valid && !evt.proto_err && evt.comm_fault |=>
      resp_q.detail == $past(evt.status1))
    else $error("status byte one not passed");

  clean_detail_a: assert property (
      evt_valid && !evt.proto_err && !evt.comm_fault |=> resp_q.detail == BYTE_ZERO)
    else $error("detail not cleared");

  no_code_a: assert property (evt_valid && !evt.proto_err |=>
      resp_q.group[7:4] == PE_UNSPEC)
    else $error("code without protocol error");

  unused_code_a: assert property (
      evt_valid && evt.proto_err && evt.proto_code > PE_LAST |=>
      resp_q.group[7:4] == PE_UNSPEC && resp_q.detail == $past(evt.proto_val))
    else $error("unused code not folded");

  low_code_a: assert property (
      evt_valid && evt.proto_err && evt.proto_code < PE_COMMAND |=>
      resp_q.detail == $past(evt.proto_val))
    else $error("plain detail not passed");

  cmd_pass_a: assert property (
      evt_valid && evt.proto_err && evt.proto_code == PE_COMMAND |=>
      resp_q.detail[6:0] == $past(evt.proto_val[6:0]))
    else $error("command value not passed");

  query_bits_a: assert property (
      evt_valid && evt.proto_err && evt.proto_code == PE_QUERY |=>
      resp_q.detail[6:3] == $past(evt.rxerr[6:3]) &&
      resp_q.detail[1] == $past(evt.rxerr.rx_overflow))
    else $error("query bits not mapped");

  rej_pass_a: assert property (
      evt_valid && evt.proto_err && evt.proto_code == PE_REJ && evt.proto_val <= REJ_MAX |=>
      resp_q.detail == $past(evt.proto_val))
    else $error("reject reason not passed");

  // Main scenarios a run should reach
  reply_c: cover property (evt_valid && evt.proto_err && evt.proto_code == PE_REPLY);
  comm_c: cover property (evt_valid && evt.comm_fault && !evt.proto_err);
  back_c: cover property (evt_valid [*2]);
  clean_c: cover property (evt_valid && !evt.proto_err && !evt.comm_fault);
  unused_c: cover property (evt_valid && evt.proto_err && evt.proto_code > PE_LAST);

endmodule
`default_nettype wire

// ### testbench/hre_client.sv
// Client model that checks the command echo of each response record
`timescale 1ns/1ps
`default_nettype none
module hre_client
  import hre_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd,
  input  wire logic       resp_valid,
  input  wire hre_resp_t  resp,
  output logic            echo_ok
);
  logic [7:0] sent_q;
  always_ff @(posedge clock) begin
    if (cmd_wr) sent_q <= cmd;
  end
  assign echo_ok = resp_valid && (resp.last_cmd === sent_q);
endmodule
`default_nettype wire

// ### testbench/hre_report_bench.sv
// Self-checking bench for the response error report block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module hre_report_bench
  import hre_pkg::*;
;
  logic       clock, sys_rst, evt_valid, resp_valid, echo_ok, seen;
  hre_event_t evt, e;
  hre_resp_t  resp, x;
  hre_resp_t  q[$];
  int         n_errors, n_tests;
  logic [31:0] rs;
  logic [63:0] r64;
  hre_report uut (.clock(clock), .sys_rst(sys_rst), .evt_valid(evt_valid), .evt(evt),
                  .resp_valid(resp_valid), .resp(resp));
  hre_client cli (.clock(clock), .cmd_wr(evt_valid), .cmd(evt.cmd_num),
                  .resp_valid(resp_valid), .resp(resp), .echo_ok(echo_ok));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic hre_resp_t model(hre_event_t v);
    hre_resp_t  m;
    logic [3:0] c;
    // codes above 8 read as unspecified
    c = !v.proto_err ? 4'h0 : (v.proto_code > PE_LAST) ? PE_UNSPEC : v.proto_code;
    m.last_cmd = v.cmd_num;
    m.group = {c, 1'b0, v.field_modem_check, v.comm_fault, v.status2[ST2_MORE_BIT]};
    if (!v.proto_err) m.detail = v.comm_fault ? v.status1 : 8'h00;
    else case (c)
      4'h3: m.detail = v.proto_val & 8'h7f;
      4'h4: m.detail = {1'b1, v.rxerr} & 8'hfa;
      4'h5: m.detail = {1'b1, v.rxerr};
      4'h6: m.detail = (v.proto_val <= 8'h04) ? v.proto_val : 8'h00;
      4'h7, 4'h8: m.detail = 8'h00;
      default: m.detail = v.proto_val;
    endcase
    return m;
  endfunction
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Result stands just after the edge that captured the event
  always @(posedge clock) begin
    seen = evt_valid && !sys_rst;
    #1;
    if (seen) begin
      x = q.pop_front();
      `CHK(resp, x)
      `CHK(resp_valid, 1'b1)
      `CHK(echo_ok, 1'b1)
    end
  end
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    rs = 32'd54112;
    n_errors = 0;
    n_tests = 0;
    seen = 1'b0;
    sys_rst = 1'b1;
    evt_valid = 1'b0;
    evt = '0;
    repeat (20) @(posedge clock);
    @(negedge clock);
    `CHK({resp_valid, resp}, 25'h0)
    sys_rst = 1'b0;
    for (int i = 0; i < 96; i++) begin
      @(negedge clock);
      r64 = {rnd(), rnd()};
      e = r64[$bits(hre_event_t)-1:0];
      e.proto_code = i[3:0];
      if (i[4]) e.proto_val = {5'h00, r64[63:61]};
      evt = e;
      if (i == 60) begin
        // Mid-run reset takes an idle slot so no result is pending
        sys_rst = 1'b1;
        evt_valid = 1'b0;
        q.delete();
        @(negedge clock);
        `CHK({resp_valid, resp}, 25'h0)
        sys_rst = 1'b0;
      end else begin
        // Every third slot idles so back-to-back and gapped captures both occur
        evt_valid = (i % 3 != 2);
        if (evt_valid) q.push_back(model(e));
      end
    end
    @(negedge clock);
    evt_valid = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(q.size(), 0)
    summarize();
  end
endmodule
`default_nettype wire
